//--- hdl/rwc_top.sv
// rwc_top: receive waveform checker with its register port and interrupt
// assumes: bus line enters raw on line_in; software stops reception first
//
// Functional notes
// - limits bit 0 switches the waveform check on or off
// - latest zero rise is 56 fs plus field at bits 22-20
// - no rise by the latest zero limit is a waveform error
// - earliest zero rise is 43 fs minus field at bits 18-16
// - latest one rise is 26 fs plus field at bits 14-12
// - rise between latest one and earliest zero is an error
// - earliest one rise is 13 fs minus field at bits 10-8
// - rise before the earliest one limit is a waveform error
// - with hold set, error interrupt waits for bit end or timeout
`timescale 1ns/1ns
`default_nettype none
module rwc_top
  import rwc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              wr,
  input  wire logic              rd,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  output var  logic [31:0]       rdata,
  input  wire logic              line_in,
  output var  logic              wave_err,
  output var  logic              bit_done,
  output var  logic              irq
);

  rwc_bus_t    bus;
  rwc_limits_t lim;
  logic [31:0] limits_reg;
  logic        rx_enable;
  logic        err_hold;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] irq_mask;
  logic        line_s;
  logic        line_d;
  logic [9:0]  div_cnt;
  logic        fs_tick;
  logic [7:0]  bit_time;
  rwc_state_t  state;
  logic        err_pend;
  logic        next_wave_err;
  logic        next_bit_done;
  logic        timeout;

  // low wins: a bit longer than this counts as a lost line
  localparam logic [7:0] TIMEOUT_FS = 8'hFF;

  function automatic logic [7:0] lim_up(input logic [7:0] base,
                                        input logic [2:0] f);
    lim_up = base + {5'h00, f};
  endfunction

  function automatic logic [7:0] lim_dn(input logic [7:0] base,
                                        input logic [2:0] f);
    lim_dn = base - {5'h00, f};
  endfunction

  assign bus = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

  always_comb begin
    lim.zero_late_limit       = limits_reg[POS_ZERO_LATE +: 3];
    lim.zero_early_limit      = limits_reg[POS_ZERO_EARLY +: 3];
    lim.one_late_limit        = limits_reg[POS_ONE_LATE +: 3];
    lim.one_early_limit       = limits_reg[POS_ONE_EARLY +: 3];
    lim.waveform_check_enable = limits_reg[POS_CHK_EN];
  end

  logic [7:0] t_zero_late;
  logic [7:0] t_zero_early;
  logic [7:0] t_one_late;
  logic [7:0] t_one_early;

  assign t_zero_late  = lim_up(BASE_ZERO_LATE, lim.zero_late_limit);
  assign t_zero_early = lim_dn(BASE_ZERO_EARLY, lim.zero_early_limit);
  assign t_one_late   = lim_up(BASE_ONE_LATE, lim.one_late_limit);
  assign t_one_early  = lim_dn(BASE_ONE_EARLY, lim.one_early_limit);

  rwc_sync u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    (line_in),
    .q    (line_s)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_d <= 1'b1;
    end else begin
      line_d <= line_s;
    end
  end

  // fs enable pulse from the system clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 10'h000;
      fs_tick <= 1'b0;
    end else if (div_cnt == FS_DIV_M1) begin
      div_cnt <= 10'h000;
      fs_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 10'h001;
      fs_tick <= 1'b0;
    end
  end

  logic fall;
  logic rise;
  assign fall = line_d & ~line_s;
  assign rise = ~line_d & line_s;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_time <= 8'h00;
    end else if (fall) begin
      bit_time <= 8'h00;
    end else if (fs_tick && bit_time != TIMEOUT_FS) begin
      bit_time <= bit_time + 8'h01;
    end
  end

  assign timeout = (state != ST_IDLE) && (bit_time == TIMEOUT_FS);

  always_comb begin
    next_wave_err = 1'b0;
    next_bit_done = 1'b0;
    case (state)
      ST_LOW: begin
        if (rise) begin
          next_bit_done = 1'b1;
          if (bit_time < t_one_early) begin
            next_wave_err = 1'b1;
          end
          if (bit_time > t_one_late && bit_time < t_zero_early) begin
            next_wave_err = 1'b1;
          end
        end else if (fs_tick && bit_time == t_zero_late) begin
          next_wave_err = 1'b1;
        end
      end
      ST_IDLE: ;
      ST_HIGH: ;
      default: ;
    endcase
    if (!lim.waveform_check_enable) begin
      next_wave_err = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else if (!rx_enable) begin
      state <= ST_IDLE;
    end else if (fall) begin
      state <= ST_LOW;
    end else begin
      case (state)
        ST_LOW: begin
          if (rise) begin
            state <= ST_HIGH;
          end else if (timeout) begin
            state <= ST_IDLE;
          end
        end
        ST_HIGH: begin
          if (timeout) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: ;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wave_err <= 1'b0;
      bit_done <= 1'b0;
    end else begin
      wave_err <= next_wave_err;
      bit_done <= next_bit_done;
    end
  end

  // held error released at bit end or timeout
  logic wave_ev;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_pend <= 1'b0;
    end else if (!err_hold || next_bit_done || timeout) begin
      err_pend <= 1'b0;
    end else if (next_wave_err) begin
      err_pend <= 1'b1;
    end
  end
  assign wave_ev = err_hold
                 ? ((err_pend | next_wave_err) & (next_bit_done | timeout))
                 : next_wave_err;

  // registers; leaves limit changes to software with reception stopped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      limits_reg <= LIMITS_RESET;
      rx_enable  <= 1'b0;
      err_hold   <= 1'b0;
      irq_mask   <= '0;
    end else if (bus.wr) begin
      case (bus.addr)
        OFS_LIMITS:   limits_reg <= bus.wdata & LIMITS_MASK;
        OFS_RX_CTRL: begin
          rx_enable <= bus.wdata[POS_RX_EN];
          err_hold  <= bus.wdata[POS_HOLD];
        end
        OFS_IRQ_MASK: irq_mask <= bus.wdata[EV_W-1:0];
        default: ;
      endcase
    end
  end

  // set wins over write-one-to-clear
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  always_comb begin
    ev_set = '0;
    ev_set[POS_EV_WAVE] = wave_ev;
    ev_set[POS_EV_BIT]  = next_bit_done;
    ev_clr = (bus.wr && bus.addr == OFS_IRQ_STAT)
           ? bus.wdata[EV_W-1:0] : '0;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat & ~ev_clr) | ev_set) & irq_mask);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      case (bus.addr)
        OFS_LIMITS:   rdata <= limits_reg;
        OFS_RX_CTRL:  rdata <= {30'h0000_0000, err_hold, rx_enable};
        OFS_IRQ_STAT: rdata <= {30'h0000_0000, irq_stat};
        OFS_IRQ_MASK: rdata <= {30'h0000_0000, irq_mask};
        default:      rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

//--- hdl/rwc_pkg.sv
// rwc_pkg: constants and types for the receive waveform checker
// assumes: one 25 MHz clock, a plain register port, fs tick made inside
package rwc_pkg;

  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  OFS_LIMITS     = 4'h0;
  localparam logic [3:0]  OFS_RX_CTRL    = 4'h4;
  localparam logic [3:0]  OFS_IRQ_STAT   = 4'h8;
  localparam logic [3:0]  OFS_IRQ_MASK   = 4'hC;

  localparam int          POS_CHK_EN     = 0;
  localparam int          POS_ONE_EARLY  = 8;
  localparam int          POS_ONE_LATE   = 12;
  localparam int          POS_ZERO_EARLY = 16;
  localparam int          POS_ZERO_LATE  = 20;
  localparam logic [31:0] LIMITS_MASK    = 32'h0077_7701;
  localparam logic [31:0] LIMITS_RESET   = 32'h0000_0000;

  localparam int          POS_RX_EN      = 0;
  localparam int          POS_HOLD       = 1;

  localparam int          POS_EV_WAVE    = 0;
  localparam int          POS_EV_BIT     = 1;
  localparam int          EV_W           = 2;

  // bases of the four limits, in fs periods
  localparam logic [7:0]  BASE_ZERO_LATE  = 8'h38;
  localparam logic [7:0]  BASE_ZERO_EARLY = 8'h2B;
  localparam logic [7:0]  BASE_ONE_LATE   = 8'h1A;
  localparam logic [7:0]  BASE_ONE_EARLY  = 8'h0D;

  // fs is 32768 Hz; clock is 25 MHz
  localparam int          CLK_HZ     = 25000000;
  localparam int          FS_HZ      = 32768;
  localparam int          FS_DIV     = CLK_HZ / FS_HZ;
  localparam logic [9:0]  FS_DIV_M1  = 10'(FS_DIV - 1);

  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [ADDR_W-1:0]    addr;
    logic [31:0]          wdata;
  } rwc_bus_t;

  typedef struct packed {
    logic [2:0] zero_late_limit;
    logic [2:0] zero_early_limit;
    logic [2:0] one_late_limit;
    logic [2:0] one_early_limit;
    logic       waveform_check_enable;
  } rwc_limits_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b11
  } rwc_state_t;

endpackage

//--- hdl/rwc_sync.sv
// rwc_sync: two-flop synchroniser for the bus line input
// assumes: input is asynchronous to clk; line idles high
`timescale 1ns/1ns
`default_nettype none
module rwc_sync (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic d,
  output var  logic q
);
  logic meta;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= 1'b1;
      q    <= 1'b1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

//--- dv/rwc_chk.sv
// rwc_chk: port assertions for the receive waveform checker
// assumes: bound to rwc_top; one clock, async active-low reset
`timescale 1ns/1ns
`default_nettype none
module rwc_chk
  import rwc_pkg::*;
(
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0]       wdata,
  input wire logic [31:0]       rdata,
  input wire logic              line_in,
  input wire logic              wave_err,
  input wire logic              bit_done,
  input wire logic              irq
);
  logic en;
  logic rx;
  logic ev;
  assign ev = wave_err | bit_done | wr;
  // enable copies seen from the bus, since the bodies are hidden
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en <= 1'b0;
      rx <= 1'b0;
    end else if (wr && addr == OFS_LIMITS) begin
      en <= wdata[POS_CHK_EN];
    end else if (wr && addr == OFS_RX_CTRL) begin
      rx <= wdata[POS_RX_EN];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data outside its cycle");
  a_resv_zero: assert property (rd && addr == OFS_LIMITS |=>
    (rdata & ~LIMITS_MASK) == '0) else $error("reserved bits set");
  a_limits_back: assert property ($past(wr, 2) && $past(rd) &&
    $past(addr, 2) == OFS_LIMITS && $past(addr) == OFS_LIMITS
    |-> rdata == ($past(wdata, 2) & LIMITS_MASK))
    else $error("limits readback wrong");
  a_err_pulse: assert property (wave_err |=> !wave_err)
    else $error("error pulse too long");
  a_done_pulse: assert property (bit_done |=> !bit_done)
    else $error("bit end pulse too long");
  a_done_rise: assert property (bit_done |->
    $past(line_in, 3) && !$past(line_in, 4))
    else $error("bit end not three cycles after rise");
  a_err_needs_en: assert property (wave_err |-> en)
    else $error("error while check disabled");
  a_quiet_off: assert property (!rx |-> !(bit_done || wave_err))
    else $error("activity while reception off");
  a_irq_cause: assert property ($rose(irq) |-> ev || $past(ev) ||
    $past(ev, 2) || $past(ev, 3)) else $error("irq without cause");
endmodule
bind rwc_top rwc_chk i_chk (.clk(clk), .nrst(nrst), .wr(wr), .rd(rd),
  .addr(addr), .wdata(wdata), .rdata(rdata), .line_in(line_in),
  .wave_err(wave_err), .bit_done(bit_done), .irq(irq));
`default_nettype wire

//--- dv/rwc_far.sv
// rwc_far: another device sending bits on the shared line
// assumes: line has a pull-up, so it reads high when released
`timescale 1ns/1ns
`default_nettype none
module rwc_far
  import rwc_pkg::*;
(
  input  wire logic clk,
  output var  logic line
);
  initial line = 1'b1;
  // one clock over whole periods: bit timer reads exactly lo_fs at the rise
  task automatic send(input int lo_fs);
    line <= 1'b0;
    repeat (lo_fs * FS_DIV + 1) @(posedge clk);
    line <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- dv/rwc_top_tb.sv
// rwc_top_tb: self-checking bench for the receive waveform checker
// assumes: rwc_far drives the line; run stays near 100k cycles
`timescale 1ns/1ns
`default_nettype none
module rwc_top_tb
  import rwc_pkg::*;
;
  logic              clk = 0, nrst = 0, wr = 0, rd = 0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0]       wdata = '0, seed = 32'h0000_004C, rdata;
  logic              line_in, wave_err, bit_done, irq;
  int                bad_count = 0, tests_run = 0, cyc = 0;
  int                n_err = 0, n_done = 0;
  always #20 clk = ~clk;
  rwc_top i_dut (.clk(clk), .nrst(nrst), .wr(wr), .rd(rd), .addr(addr),
    .wdata(wdata), .rdata(rdata), .line_in(line_in),
    .wave_err(wave_err), .bit_done(bit_done), .irq(irq));
  rwc_far i_far (.clk(clk), .line(line_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic bit exp_err(input int t, input logic [31:0] c);
    int oe, ol, ze, zl;
    oe = 13 - c[10:8];
    ol = 26 + c[14:12];
    ze = 43 - c[18:16];
    zl = 56 + c[22:20];
    return c[0] && (t < oe || (t > ol && t < ze) || t > zl);
  endfunction
  task automatic chk(input logic [31:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic bus(input logic w, r, input logic [3:0] a,
                     input logic [31:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(0, 1, a, '0);
    // data stands in the cycle after the strobe; taken at its closing edge
    bus(0, 0, '0, '0);
    chk(rdata, e, "read data");
  endtask
  // stop reception and confirm before touching the limits
  task automatic setup(input logic [31:0] c, ctl);
    bus(1, 0, OFS_RX_CTRL, '0);
    rchk(OFS_RX_CTRL, '0);
    bus(1, 0, OFS_LIMITS, c);
    bus(1, 0, OFS_IRQ_STAT, 32'h0000_0003);
    bus(1, 0, OFS_RX_CTRL, ctl);
    bus(0, 0, '0, '0);
  endtask
  task automatic bit_chk(input int t, input logic [31:0] c);
    n_err = 0;
    n_done = 0;
    i_far.send(t);
    chk(n_err != 0, exp_err(t, c), "error flag");
    chk(n_done, 1, "bit end count");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ceiling sits above the ~95k cycles the bits need
  always @(posedge clk) begin
    cyc++;
    n_err += int'(wave_err === 1'b1);
    n_done += int'(bit_done === 1'b1);
    if (cyc == 110000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    logic [31:0] c;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 16; a += 4)
      rchk(4'(a), LIMITS_RESET);
    rchk(4'h2, '0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bus(1, 0, OFS_LIMITS, seed);
      rchk(OFS_LIMITS, seed & LIMITS_MASK);
      bus(1, 0, 4'h2, ~seed);
      rchk(OFS_LIMITS, seed & LIMITS_MASK);
    end
    // limits 6, 26, 36, 56 fs; check off first
    c = 32'h0007_0700;
    bus(1, 0, OFS_IRQ_MASK, 32'h0000_0001);
    setup(c, 32'h0000_0001);
    bit_chk(2, c);
    chk(irq, 0, "irq without error");
    c[0] = 1'b1;
    setup(c, 32'h0000_0001);
    bit_chk(5, c);
    rchk(OFS_IRQ_STAT, 32'h0000_0003);
    chk(irq, 1, "irq on error");
    bus(1, 0, OFS_IRQ_STAT, 32'h0000_0003);
    bus(0, 0, '0, '0);
    bus(0, 0, '0, '0);
    chk(irq, 0, "irq cleared");
    bit_chk(6, c);
    bit_chk(26, c);
    bit_chk(27, c);
    setup(c, 32'h0000_0003);
    fork
      bit_chk(58, c);
      begin
        repeat (58 * FS_DIV) @(posedge clk);
        chk(n_err, 1, "late error");
        chk(irq, 0, "irq held");
      end
    join
    chk(irq, 1, "irq released");
    conclude();
  end
endmodule
`default_nettype wire
